// ==== core/bcc_pkg.sv ====
// constants and carrier types for the buffered compare counter
package bcc_pkg;

    localparam int CNT_W   = 16;
    localparam int CH_N    = 4;
    localparam int FLAG_N  = 5;  // four channel flags plus overflow
    localparam int OVF_IDX = 4;

    // byte offsets on the register bus
    localparam logic [7:0] OFS_MAIN    = 8'h00;
    localparam logic [7:0] OFS_COUNT   = 8'h04;
    localparam logic [7:0] OFS_MODULO  = 8'h08;
    localparam logic [7:0] OFS_BRK     = 8'h0C;
    localparam logic [7:0] OFS_CH_BASE = 8'h10;
    localparam logic [7:0] OFS_CH_STEP = 8'h08;
    localparam logic [7:0] OFS_CMP     = 8'h04;
    localparam logic [7:0] OFS_CH_END  = 8'h30;
    localparam int CH_IDX_LSB  = 3;
    localparam int CMP_SEL_BIT = 2;
    localparam int TRANS_BIT   = 1;  // htrans bit that marks NONSEQ or SEQ

    // field positions
    localparam int FLAG_BIT    = 7;
    localparam int IE_BIT      = 6;
    localparam int LINK_BIT    = 5;
    localparam int STOP_BIT    = 5;
    localparam int OCEN_BIT    = 4;
    localparam int CRST_BIT    = 4;
    localparam int ACT_LSB     = 2;
    localparam int BRK_CLR_BIT = 7;

    // pin actions on a compare match
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;

    // values after reset
    localparam logic [15:0] RST_COUNT  = 16'h0000;
    localparam logic [15:0] RST_MODULO = 16'hFFFF;
    localparam logic [15:0] RST_CMP    = 16'hFFFF;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } bcc_ahb_req_s;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } bcc_ahb_rsp_s;

    typedef struct packed {
        logic       ie;
        logic       link;
        logic       ocEn;
        logic [1:0] act;
    } bcc_chctrl_s;

endpackage

// ==== core/bcc_compare_counter.sv ====
// buffered output compare counter unit with an AHB-Lite register slave
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module bcc_compare_counter (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire bcc_pkg::bcc_ahb_req_s ahbReq,
    output var  bcc_pkg::bcc_ahb_rsp_s ahbRsp,
    input  wire logic                  waitMode,
    input  wire logic                  stopMode,
    input  wire logic                  breakActive,
    output logic [3:0]                 channelPin,
    output logic [3:0]                 channelPinOwned,
    output logic [3:0]                 chanIrq,
    output logic                       ovfIrq,
    output logic                       wakeReq
);

    localparam int CN = bcc_pkg::CH_N;
    localparam int FN = bcc_pkg::FLAG_N;
    localparam int OV = bcc_pkg::OVF_IDX;

    // bus side state
    logic        wrPend_q;
    logic [7:0]  wrOfs_q;
    logic [31:0] rdData_q;
    logic [31:0] rdMux;

    // main counter state
    logic        ovfIe_q;
    logic        stop_q;
    logic        clrEn_q;
    logic [15:0] modulo_q;
    logic [15:0] count_q;
    logic [15:0] count_d;

    // channel and flag state
    bcc_pkg::bcc_chctrl_s ctrlQ [CN];
    logic [15:0]          cmpQ [CN];
    logic                 pinQ [CN];
    logic                 flagQ [FN];
    logic                 armQ [FN];
    logic                 activeQ [2];
    logic                 pendQ [2];

    wire logic [15:0] effCmp [CN];
    wire logic [31:0] ctrlRd [CN];
    wire logic [31:0] cmpRd [CN];
    wire logic [CN-1:0] slave;
    wire logic [CN-1:0] hit;
    wire logic [CN-1:0] wrCtrl;
    wire logic [CN-1:0] wrCmp;
    wire logic [FN-1:0] flagSet;
    wire logic [FN-1:0] flagIgn;
    wire logic [1:0]    pairLink;

    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // address phase decode; in wait mode the bus sees a closed window
    wire logic        addrPhase = ahbReq.hsel & ahbReq.htrans[bcc_pkg::TRANS_BIT]
                                  & ahbReq.hready;
    wire logic        busOpen   = addrPhase & ~waitMode;
    wire logic        rdStrobe  = busOpen & ~ahbReq.hwrite;
    wire logic [7:0]  aOfs      = ahbReq.haddr[7:0];
    wire logic        aMapped   = ahbReq.haddr[31:8] == 24'h00_0000;
    wire logic [7:0]  chRel     = aOfs - bcc_pkg::OFS_CH_BASE;
    wire logic [1:0]  chIdx     = chRel[bcc_pkg::CH_IDX_LSB +: 2];
    wire logic [31:0] wrData    = ahbReq.hwdata;

    // data phase decode of the latched write
    wire logic wrMain = wrPend_q & (wrOfs_q == bcc_pkg::OFS_MAIN);
    wire logic wrMod  = wrPend_q & (wrOfs_q == bcc_pkg::OFS_MODULO);
    wire logic wrBrk  = wrPend_q & (wrOfs_q == bcc_pkg::OFS_BRK);
    wire logic cntRst = wrMain & wrData[bcc_pkg::CRST_BIT];

    // zero wait states, always OKAY
    assign ahbRsp = '{hrdata: rdData_q, hreadyout: 1'b1, hresp: 1'b0};

    // read data is captured in the address phase so hrdata comes from a flop
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPend_q <= 1'b0;
            wrOfs_q  <= 8'h00;
            rdData_q <= 32'h0000_0000;
        end
        else
        begin
            wrPend_q <= busOpen & ahbReq.hwrite & aMapped;
            wrOfs_q  <= aOfs;
            rdData_q <= rdStrobe ? rdMux : 32'h0000_0000;
        end
    end

    // register read selection; unmapped words read as zero
    always_comb
    begin
        rdMux = 32'h0000_0000;
        if (!aMapped)
            rdMux = 32'h0000_0000;
        else if (aOfs == bcc_pkg::OFS_MAIN)
            rdMux = {24'h00_0000, flagQ[OV], ovfIe_q, stop_q, 5'h00};
        else if (aOfs == bcc_pkg::OFS_COUNT)
            rdMux = {16'h0000, count_q};
        else if (aOfs == bcc_pkg::OFS_MODULO)
            rdMux = {16'h0000, modulo_q};
        else if (aOfs == bcc_pkg::OFS_BRK)
            rdMux = {24'h00_0000, clrEn_q, 7'h00};
        else if (aOfs >= bcc_pkg::OFS_CH_BASE && aOfs < bcc_pkg::OFS_CH_END
                 && aOfs[1:0] == 2'h0)
            rdMux = aOfs[bcc_pkg::CMP_SEL_BIT] ? cmpRd[chIdx] : ctrlRd[chIdx];
    end

    // counter runs unless stopped by software, stop mode or a break
    wire logic tick  = ~stop_q & ~stopMode & ~breakActive;
    wire logic ovfEv = tick & (count_q == modulo_q);
    wire logic protect = breakActive & ~clrEn_q;

    // wrap to zero at the end of the period at the modulo value
    assign count_d = (cntRst | ovfEv) ? bcc_pkg::RST_COUNT
                   : tick ? count_q + 16'h0001 : count_q;

    // main control, modulo and break clear enable
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ovfIe_q  <= 1'b0;
            stop_q   <= 1'b0;
            clrEn_q  <= 1'b0;
            modulo_q <= bcc_pkg::RST_MODULO;
            count_q  <= bcc_pkg::RST_COUNT;
        end
        else
        begin
            if (wrMain)
            begin
                ovfIe_q <= wrData[bcc_pkg::IE_BIT];
                stop_q  <= wrData[bcc_pkg::STOP_BIT];
            end
            if (wrMod)
                modulo_q <= wrData[15:0];
            if (wrBrk)
                clrEn_q <= wrData[bcc_pkg::BRK_CLR_BIT];
            count_q <= count_d;
        end
    end

    sequence sOvfTick;
        tick && (count_q == modulo_q);
    endsequence

    AST_OVF_FLAG: assert property (sOvfTick |=> flagQ[OV])
        else $error("overflow flag missing after modulo reached");
    AST_OVF_WRAP: assert property ((sOvfTick ##0 !cntRst) |=> count_q == 16'h0000)
        else $error("counter did not wrap at modulo");
    AST_FREEZE: assert property (breakActive && !cntRst |=> $stable(count_q))
        else $error("counter moved during break");
    AST_WAIT_BLOCK: assert property (waitMode && addrPhase |=> !wrPend_q && rdData_q == 0)
        else $error("register access taken in wait mode");

    // link bits live in the even channel controls
    assign pairLink = {ctrlQ[2].link, ctrlQ[0].link};

    genvar gi;
    generate
        for (gi = 0; gi < CN; gi++)
        begin : g_ch
            localparam logic [7:0] COFS = 8'(bcc_pkg::OFS_CH_BASE + gi * bcc_pkg::OFS_CH_STEP);
            localparam int  PAIR = gi / 2;
            localparam bit  ODD  = (gi % 2) == 1;
            localparam logic CAN_LINK = !ODD;

            wire logic [1:0] act = ctrlQ[gi].act;
            wire logic pinNext = (act == bcc_pkg::ACT_SET)    ? 1'b1
                               : (act == bcc_pkg::ACT_CLEAR)  ? 1'b0
                               : (act == bcc_pkg::ACT_TOGGLE) ? ~pinQ[gi] : pinQ[gi];

            // control writes to the slave half of a linked pair are dropped
            assign wrCtrl[gi] = wrPend_q & (wrOfs_q == COFS) & ~slave[gi];
            assign wrCmp[gi]  = wrPend_q & (wrOfs_q == (COFS | bcc_pkg::OFS_CMP));

            if (ODD)
            begin : g_odd
                assign slave[gi]  = pairLink[PAIR];
                assign effCmp[gi] = cmpQ[gi];
            end
            else
            begin : g_even
                wire logic pendD = wrCmp[gi + 1] ? 1'b1 : wrCmp[gi] ? 1'b0 : pendQ[PAIR];

                assign slave[gi]  = 1'b0;
                assign effCmp[gi] = (pairLink[PAIR] & activeQ[PAIR]) ? cmpQ[gi + 1] : cmpQ[gi];

                // unlinked pairs sit on the even channel so linking starts there
                always_ff @(posedge clock or negedge rst_n)
                begin
                    if (!rst_n)
                    begin
                        activeQ[PAIR] <= 1'b0;
                        pendQ[PAIR]   <= 1'b0;
                    end
                    else if (!pairLink[PAIR])
                    begin
                        activeQ[PAIR] <= 1'b0;
                        pendQ[PAIR]   <= 1'b0;
                    end
                    else
                    begin
                        pendQ[PAIR] <= pendD;
                        if (ovfEv)
                            activeQ[PAIR] <= pendD;
                    end
                end
            end

            // equality only: a value the counter already passed waits a period
            assign hit[gi] = tick & ctrlQ[gi].ocEn & ~slave[gi]
                             & (count_q == effCmp[gi]);

            assign ctrlRd[gi] = slave[gi] ? 32'h0000_0000
                              : {24'h00_0000, flagQ[gi], ctrlQ[gi].ie, ctrlQ[gi].link,
                                 ctrlQ[gi].ocEn, ctrlQ[gi].act, 2'h0};
            assign cmpRd[gi]  = {16'h0000, cmpQ[gi]};

            assign channelPin[gi]      = pinQ[gi];
            assign channelPinOwned[gi] = ctrlQ[gi].ocEn & ~slave[gi];
            assign chanIrq[gi]         = flagQ[gi] & ctrlQ[gi].ie;

            // channel control, compare value and pin level
            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    ctrlQ[gi] <= '0;
                    cmpQ[gi]  <= bcc_pkg::RST_CMP;
                    pinQ[gi]  <= 1'b0;
                end
                else
                begin
                    if (wrCtrl[gi])
                        ctrlQ[gi] <= '{ie:   wrData[bcc_pkg::IE_BIT],
                                       link: wrData[bcc_pkg::LINK_BIT] & CAN_LINK,
                                       ocEn: wrData[bcc_pkg::OCEN_BIT],
                                       act:  wrData[bcc_pkg::ACT_LSB +: 2]};
                    if (wrCmp[gi])
                        cmpQ[gi] <= wrData[15:0];
                    if (hit[gi])
                        pinQ[gi] <= pinNext;
                end
            end
        end
    endgenerate

    assign flagSet = {ovfEv, hit};
    assign flagIgn = {1'b0, slave};

    // two-step clear: read with the flag set, then write zero to it;
    // a new event in the clearing cycle wins, so no match is lost
    genvar gk;
    generate
        for (gk = 0; gk < FN; gk++)
        begin : g_flag
            localparam logic [7:0] FOFS = (gk == OV) ? bcc_pkg::OFS_MAIN
                : 8'(bcc_pkg::OFS_CH_BASE + gk * bcc_pkg::OFS_CH_STEP);

            wire logic rdArm  = rdStrobe & aMapped & (aOfs == FOFS)
                                & ~flagIgn[gk] & ~protect;
            wire logic clrReq = wrPend_q & (wrOfs_q == FOFS) & ~wrData[bcc_pkg::FLAG_BIT]
                                & ~flagIgn[gk] & armQ[gk] & ~protect;

            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    flagQ[gk] <= 1'b0;
                    armQ[gk]  <= 1'b0;
                end
                else
                begin
                    flagQ[gk] <= flagSet[gk] | (flagQ[gk] & ~clrReq);
                    armQ[gk]  <= flagQ[gk] & ~clrReq & (armQ[gk] | rdArm);
                end
            end
        end
    endgenerate

    // overflow request gated by its enable; any request wakes the core
    assign ovfIrq  = flagQ[OV] & ovfIe_q;
    assign wakeReq = ovfIrq | (|chanIrq);

    sequence sOddLoad;
        pairLink[0] && (wrCmp[1] || pendQ[0]) && !wrCmp[0];
    endsequence

    AST_OVF_IRQ: assert property ((sOvfTick ##0 (ovfIe_q && !wrMain)) |=> ovfIrq)
        else $error("enabled overflow gave no request");
    AST_PIN_SET: assert property (hit[0] && ctrlQ[0].act == bcc_pkg::ACT_SET |=> channelPin[0])
        else $error("set action did not drive pin high");
    AST_CH_FLAG: assert property (hit[0] |=> flagQ[0])
        else $error("channel flag missing after match");
    AST_PROTECT: assert property (protect && flagQ[0] |=> flagQ[0])
        else $error("flag cleared during protected break");
    AST_TWO_STEP: assert property (protect && armQ[0] |=> armQ[0])
        else $error("first clear step lost during break");
    AST_LINK_INIT: assert property ($rose(pairLink[0]) |-> !activeQ[0])
        else $error("linked pair did not start on even channel");
    AST_HANDOVER: assert property ((sOddLoad ##0 ovfEv) |=> activeQ[0])
        else $error("odd channel did not take pin at overflow");
    AST_RELEASE: assert property (pairLink[0] |-> !channelPinOwned[1] && !hit[1])
        else $error("linked odd pin still owned");
    AST_IGNORE: assert property (pairLink[0] && !flagQ[1] |=> !flagQ[1])
        else $error("ignored channel flag rose while linked");

    // pair 2/3 mirrors pair 0/1; a compare write in the overflow cycle counts
    sequence sOddLoad23;
        pairLink[1] && (wrCmp[3] || pendQ[1]) && !wrCmp[2];
    endsequence

    // even channel written last, so the pin returns to it at overflow
    sequence sEvenPend;
        pairLink[0] && !wrCmp[1] && (wrCmp[0] || !pendQ[0]);
    endsequence

    // a clear that break leaves open once its enable is set
    sequence sOpenClear;
        breakActive && clrEn_q && armQ[3] && wrCtrl[3] && !wrData[bcc_pkg::FLAG_BIT];
    endsequence

    AST_BACK_EVEN: assert property ((sEvenPend ##0 ovfEv) |=> !activeQ[0])
        else $error("even channel did not take pin back at overflow");
    AST_HANDOVER23: assert property ((sOddLoad23 ##0 ovfEv) |=> activeQ[1])
        else $error("channel 3 did not take pin at overflow");
    AST_LINK_INIT23: assert property ($rose(pairLink[1]) |-> !activeQ[1])
        else $error("pair 2/3 did not start on channel 2");
    AST_RELEASE23: assert property (pairLink[1] |-> !channelPinOwned[3] && !hit[3])
        else $error("linked channel 3 pin still owned");
    AST_OWN1: assert property (!pairLink[0] && ctrlQ[1].ocEn |-> channelPinOwned[1])
        else $error("unlinked channel 1 pin not driven");

    // stop mode, open break window and channel requests
    AST_STOP_HOLD: assert property (stopMode && !cntRst |=> $stable(count_q))
        else $error("counter moved in stop mode");
    AST_OPEN_CLEAR: assert property ((sOpenClear ##0 !hit[3]) |=> !flagQ[3])
        else $error("flag clear refused with break clear enabled");
    AST_CH_IRQ: assert property (hit[2] && ctrlQ[2].ie && !wrCtrl[2] |=> chanIrq[2])
        else $error("enabled channel match gave no request");

endmodule

`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the buffered compare counter over its register bus
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                  clock;
    logic                  rst_n;
    logic                  hsel;
    logic [31:0]           haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [31:0]           hwdata;
    bcc_pkg::bcc_ahb_req_s ahbReq;
    bcc_pkg::bcc_ahb_rsp_s ahbRsp;
    logic                  waitMode;
    logic                  stopMode;
    logic                  breakActive;
    logic [3:0]            channelPin;
    logic [3:0]            channelPinOwned;
    logic [3:0]            chanIrq;
    logic                  ovfIrq;
    logic                  wakeReq;
    logic [3:0]            pinPrev;
    int                    gapCnt[4];
    int                    gapLast[4];
    int                    n_errors;
    int                    checks;
    logic [31:0]           va;
    logic [31:0]           vb;

    // single slave: its hreadyout is the bus hready
    assign ahbReq = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, ahbRsp.hreadyout};

    bcc_compare_counter uut (
        .clock           (clock),
        .rst_n           (rst_n),
        .ahbReq          (ahbReq),
        .ahbRsp          (ahbRsp),
        .waitMode        (waitMode),
        .stopMode        (stopMode),
        .breakActive     (breakActive),
        .channelPin      (channelPin),
        .channelPinOwned (channelPinOwned),
        .chanIrq         (chanIrq),
        .ovfIrq          (ovfIrq),
        .wakeReq         (wakeReq)
    );

    always #20 clock = ~clock;

    // cycles between pin changes; tells which channel of a pair owns the pin
    always @(posedge clock)
    begin
        pinPrev <= channelPin;
        for (int i = 0; i < 4; i++)
        begin
            if (channelPin[i] !== pinPrev[i])
            begin
                gapLast[i] <= gapCnt[i];
                gapCnt[i]  <= 1;
            end
            else
                gapCnt[i] <= gapCnt[i] + 1;
        end
    end

    task automatic conclude();
        if (n_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one single transfer: address phase, then data phase, both held until hready
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (ahbRsp.hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (ahbRsp.hreadyout !== 1'b1);
        rd = ahbRsp.hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(a, 1'b1, d, dummy);
    endtask

    task automatic rc(input logic [31:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] d;
        xfer(a, 1'b0, 32'h0000_0000, d);
        check(nm, exp, d);
    endtask

    function automatic logic [31:0] chA(input int n, input bit cmp);
        return {24'h00_0000, bcc_pkg::OFS_CH_BASE + 8'(n) * bcc_pkg::OFS_CH_STEP
                + (cmp ? bcc_pkg::OFS_CMP : 8'h00)};
    endfunction

    // bounded wait for the next change on pin 0
    task automatic waitToggle();
        logic p;
        p = channelPin[0];
        for (int k = 0; k < 100 && channelPin[0] === p; k++)
            @(posedge clock);
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        n_errors++;
        conclude();
    end

    initial
    begin
        clock = 1'b0; rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000;
        htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0000_0000;
        waitMode = 1'b0; stopMode = 1'b0; breakActive = 1'b0;
        n_errors = 0; checks = 0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        // reset values and an unmapped place
        rc(32'h0000_0000, 32'h0000_0000, "main");
        rc(32'h0000_0008, 32'h0000_FFFF, "modulo");
        rc(chA(0, 1), 32'h0000_FFFF, "cmp0");
        rc(32'h0000_0040, 32'h0000_0000, "unmapped");
        // stop and clear the counter, period of 20 counts
        wr(32'h0000_0000, 32'h0000_0030);
        rc(32'h0000_0004, 32'h0000_0000, "count");
        rc(32'h0000_0000, 32'h0000_0020, "main stopped");
        wr(32'h0000_0008, 32'h0000_0013);
        for (int n = 0; n < 4; n++)
            wr(chA(n, 1), 32'(5 + 2 * n));
        // set, toggle, toggle, none; channel 1 has no interrupt enable
        wr(chA(0, 0), 32'h0000_005C);
        wr(chA(1, 0), 32'h0000_0014);
        wr(chA(2, 0), 32'h0000_0054);
        wr(chA(3, 0), 32'h0000_0050);
        @(posedge clock);
        check("owned", 32'h0000_000F, 32'(channelPinOwned));
        wr(32'h0000_0000, 32'h0000_0000);
        repeat (15) @(posedge clock);
        check("pins", 32'h0000_0007, 32'(channelPin));
        check("chanIrq", 32'h0000_000D, 32'(chanIrq));
        repeat (10) @(posedge clock);
        rc(32'h0000_0000, 32'h0000_0080, "ovf flag");
        check("ovfIrq off", 32'h0000_0000, 32'(ovfIrq));
        wr(32'h0000_0000, 32'h0000_00C0);
        @(posedge clock);
        check("ovfIrq on", 32'h0000_0001, 32'(ovfIrq));
        wr(chA(1, 0), 32'h0000_0018);
        repeat (20) @(posedge clock);
        check("pins again", 32'h0000_0005, 32'(channelPin));
        // wait mode: registers closed, interrupts still wake
        waitMode <= 1'b1;
        rc(32'h0000_0008, 32'h0000_0000, "wait read");
        check("wake", 32'h0000_0001, 32'(wakeReq));
        check("hresp", 32'h0000_0000, 32'(ahbRsp.hresp));
        waitMode <= 1'b0;
        // stop mode then break: count holds, resumes after
        for (int m = 0; m < 2; m++)
        begin
            if (m == 0)
                stopMode <= 1'b1;
            else
                breakActive <= 1'b1;
            xfer(32'h0000_0004, 1'b0, 32'h0000_0000, va);
            repeat (10) @(posedge clock);
            rc(32'h0000_0004, va, "count frozen");
            stopMode    <= 1'b0;
            breakActive <= 1'b0;
            repeat (3) @(posedge clock);
            xfer(32'h0000_0004, 1'b0, 32'h0000_0000, vb);
            check("count runs", 32'h0000_0001, 32'(vb !== va));
        end
        rc(32'h0000_0008, 32'h0000_0013, "modulo kept");
        // two-step clear of the overflow flag, counter stopped from here
        rc(32'h0000_0000, 32'h0000_00C0, "main armed");
        wr(32'h0000_0000, 32'h0000_0060);
        rc(32'h0000_0000, 32'h0000_0060, "ovf cleared");
        // first step before break, protected during break, cleared after
        rc(chA(0, 0), 32'h0000_00DC, "ch0 armed");
        breakActive <= 1'b1;
        wr(chA(0, 0), 32'h0000_005C);
        rc(chA(0, 0), 32'h0000_00DC, "ch0 kept");
        breakActive <= 1'b0;
        wr(chA(0, 0), 32'h0000_005C);
        rc(chA(0, 0), 32'h0000_005C, "ch0 cleared");
        check("chanIrq0", 32'h0000_0000, 32'(chanIrq[0]));
        // with clear enable set, a clear in break sticks
        wr(32'h0000_000C, 32'h0000_0080);
        breakActive <= 1'b1;
        rc(chA(3, 0), 32'h0000_00D0, "ch3 armed");
        wr(chA(3, 0), 32'h0000_0050);
        breakActive <= 1'b0;
        rc(chA(3, 0), 32'h0000_0050, "ch3 cleared");
        wr(32'h0000_000C, 32'h0000_0000);
        // buffered pairs: odd compare 11, even 5, toggle on the even pin
        for (int n = 0; n < 4; n++)
            wr(chA(n, 0), 32'h0000_0000);
        wr(32'h0000_0000, 32'h0000_0030);
        for (int n = 0; n < 4; n++)
            wr(chA(n, 1), (n % 2) ? 32'h0000_000B : 32'h0000_0005);
        wr(chA(0, 0), 32'h0000_0034);
        wr(chA(2, 0), 32'h0000_0034);
        @(posedge clock);
        check("owned linked", 32'h0000_0005, 32'(channelPinOwned));
        wr(chA(1, 0), 32'h0000_005C);
        wr(chA(3, 0), 32'h0000_005C);
        rc(chA(1, 0), 32'h0000_0000, "ch1 ignored");
        rc(chA(3, 0), 32'h0000_0000, "ch3 ignored");
        wr(32'h0000_0000, 32'h0000_0000);
        waitToggle();
        waitToggle();
        @(posedge clock);
        check("gap even", 32'h0000_0014, 32'(gapLast[0]));
        check("gap even 2", 32'h0000_0014, 32'(gapLast[2]));
        wr(chA(1, 1), 32'h0000_000B);
        wr(chA(3, 1), 32'h0000_000B);
        waitToggle();
        wr(chA(0, 1), 32'h0000_0005);
        wr(chA(2, 1), 32'h0000_0005);
        check("gap to odd", 32'h0000_001A, 32'(gapLast[0]));
        check("gap to odd 2", 32'h0000_001A, 32'(gapLast[2]));
        waitToggle();
        @(posedge clock);
        check("gap to even", 32'h0000_000E, 32'(gapLast[0]));
        check("gap to even 2", 32'h0000_000E, 32'(gapLast[2]));
        waitToggle();
        @(posedge clock);
        check("gap stays", 32'h0000_0014, 32'(gapLast[0]));
        conclude();
    end
endmodule

`default_nettype wire
